// >>> design/crsf_pkg.sv
package crsf_pkg;

   // ***************************************************************
   // bus and register map
   // ***************************************************************
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] ALIGN_BITS = 2'h0;
   localparam logic [13:0] ADDR_HI_ZERO = 14'h0000;

   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_CONFIG_THREE = 16'hFFD5;
   localparam logic [15:0] IDX_SLOT_FORMAT = 16'hFFD6;
   localparam logic [15:0] IDX_PORT_CTRL = 16'hFFC0;
   localparam logic [15:0] IDX_RX_DATA = 16'hFFC1;
   localparam logic [15:0] IDX_RX_STATUS = 16'hFFC2;

   localparam logic [7:0] CONFIG_THREE_RST = 8'h30;
   localparam logic [7:0] SLOT_FORMAT_RST = 8'h00;
   localparam logic [7:0] SLOT_FORMAT_RW = 8'h3F;
   localparam logic [2:0] PORT_CTRL_RST = 3'h0;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   // ***************************************************************
   // fields
   // ***************************************************************
   localparam int WIDTH_SEL_LSB = 3;
   localparam int WIDTH_SEL_MSB = 5;
   localparam int LEN_SEL_LSB = 0;
   localparam int LEN_SEL_MSB = 2;
   localparam int MODE_MSB = 2;
   localparam int ST_NEW = 0;
   localparam int ST_LOST = 1;
   localparam int ST_SLOT_LSB = 4;
   localparam int ST_SLOT_MSB = 7;
   localparam logic [2:0] MODE_I2S_5 = 3'h5;

   // ***************************************************************
   // slot geometry
   // ***************************************************************
   localparam logic [5:0] BITS_8 = 6'h08;
   localparam logic [5:0] BITS_16 = 6'h10;
   localparam logic [5:0] BITS_18 = 6'h12;
   localparam logic [5:0] BITS_20 = 6'h14;
   localparam logic [5:0] BITS_24 = 6'h18;
   localparam logic [5:0] BITS_32 = 6'h20;
   localparam logic [5:0] DEF_WIDTH = 6'h10;
   localparam logic [5:0] DEF_LEN = 6'h10;
   localparam logic [5:0] SEC_WIDTH = 6'h10;
   localparam logic [3:0] SEC_ADDR_SLOT = 4'h1;
   localparam logic [3:0] SEC_DATA_SLOT = 4'h2;
   localparam logic [3:0] SLOT_ONE = 4'h1;
   localparam logic [5:0] BIT_ONE = 6'h01;

   typedef enum logic [0:0] {
      CRSF_HUNT = 1'b0,
      CRSF_RUN = 1'b1
   } crsf_lstate_t;

   // decode of a 3-bit width or length code
   function automatic logic [5:0] crsf_code_bits(input logic [2:0] code);
      case (code)
         3'h0: crsf_code_bits = BITS_8;
         3'h1: crsf_code_bits = BITS_16;
         3'h2: crsf_code_bits = BITS_18;
         3'h3: crsf_code_bits = BITS_20;
         3'h4: crsf_code_bits = BITS_24;
         3'h5: crsf_code_bits = BITS_32;
         default: crsf_code_bits = BITS_8;
      endcase
   endfunction

   function automatic logic [31:0] crsf_byte_addr(input logic [15:0] idx);
      crsf_byte_addr = {ADDR_HI_ZERO, idx, ALIGN_BITS};
   endfunction

endpackage

// >>> design/crsf_rx_slot_format.sv
`timescale 1ns/1ns
// Function
// - width and length settings apply only in codec port mode 5
// - data bits per slot from bits 5:3, codes 8..32, two reserved
// - secondary address and data slots ignore programmed data width
// - slot length in serial clocks from bits 2:0, same codes
// - one programmed length is used for every slot of the frame
// - bits 7:6 of slot format register read as zero
module crsf_rx_slot_format (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, high
   input wire logic hsel, // slave select
   input wire logic [crsf_pkg::ADDR_W-1:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [crsf_pkg::DATA_W-1:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [crsf_pkg::DATA_W-1:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // response, always okay
   input wire logic codec_serial_clock, // link clock
   input wire logic frame_sync, // marks bit 0 of slot 0
   input wire logic serial_data // serial data, msb first
);
   import crsf_pkg::*;

   // ***************************************************************
   // register bus
   // ***************************************************************
   logic [7:0] config_three_q, config_three_d;
   logic [7:0] slot_format_q, slot_format_d;
   logic [2:0] port_ctrl_q, port_ctrl_d;
   logic [31:0] rx_data_q;
   logic rx_new_q, rx_lost_q;
   logic [3:0] rx_slot_q;
   logic wr_pend_q;
   logic [31:0] wr_addr_q;
   logic addr_phase;
   logic [31:0] rd_word;
   logic data_take;
   logic new_clr;

   assign addr_phase = hsel && htrans == HTRANS_NONSEQ && hready;

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= ZERO32;
      end else begin
         wr_pend_q <= addr_phase && hwrite;
         wr_addr_q <= haddr;
      end
   end

   always_comb begin
      config_three_d = config_three_q;
      slot_format_d = slot_format_q;
      port_ctrl_d = port_ctrl_q;
      new_clr = 1'b0;
      if (wr_pend_q) begin
         if (wr_addr_q == crsf_byte_addr(IDX_CONFIG_THREE)) begin
            config_three_d = hwdata[7:0];
         end else if (wr_addr_q == crsf_byte_addr(IDX_SLOT_FORMAT)) begin
            slot_format_d = hwdata[7:0] & SLOT_FORMAT_RW;
         end else if (wr_addr_q == crsf_byte_addr(IDX_PORT_CTRL)) begin
            port_ctrl_d = hwdata[MODE_MSB:0];
         end else if (wr_addr_q == crsf_byte_addr(IDX_RX_STATUS)) begin
            new_clr = hwdata[ST_NEW];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         config_three_q <= CONFIG_THREE_RST;
         slot_format_q <= SLOT_FORMAT_RST;
         port_ctrl_q <= PORT_CTRL_RST;
      end else begin
         config_three_q <= config_three_d;
         slot_format_q <= slot_format_d;
         port_ctrl_q <= port_ctrl_d;
      end
   end

   // reads of config three, slot format and port control see a write finishing in the same cycle
   always_comb begin
      rd_word = ZERO32;
      if (haddr == crsf_byte_addr(IDX_CONFIG_THREE)) begin
         rd_word = {24'h000000, config_three_d};
      end else if (haddr == crsf_byte_addr(IDX_SLOT_FORMAT)) begin
         rd_word = {24'h000000, slot_format_d & SLOT_FORMAT_RW};
      end else if (haddr == crsf_byte_addr(IDX_PORT_CTRL)) begin
         rd_word = {29'h00000000, port_ctrl_d};
      end else if (haddr == crsf_byte_addr(IDX_RX_DATA)) begin
         rd_word = rx_data_q;
      end else if (haddr == crsf_byte_addr(IDX_RX_STATUS)) begin
         rd_word = {24'h000000, rx_slot_q, 2'h0, rx_lost_q, rx_new_q};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata <= ZERO32;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_phase && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   // ***************************************************************
   // settings handed to the link domain
   // ***************************************************************
   logic [6:0] cfg_live;
   logic [6:0] cfg_hold_q;
   logic cfg_req_q;
   logic cfg_ack_s;

   assign cfg_live = {port_ctrl_q == MODE_I2S_5, slot_format_q[5:0]};

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_hold_q <= 7'h00;
         cfg_req_q <= 1'b0;
      end else if (cfg_ack_s == cfg_req_q && cfg_live != cfg_hold_q) begin
         cfg_hold_q <= cfg_live;
         cfg_req_q <= ~cfg_req_q;
      end
   end

   // ***************************************************************
   // link domain: reset, crossings
   // ***************************************************************
   logic link_rst;
   logic cfg_req_s;
   logic cfg_ack_q;
   logic [6:0] cfg_link_q;
   logic word_req_q;
   logic word_ack_q;
   logic word_req_s;
   logic word_ack_s;
   logic word_seen_q;

   crsf_sync3 u_rst_sync (.clk(codec_serial_clock), .rst(1'b0), .d(rst),
      .q(link_rst));
   crsf_sync3 u_cfg_req_sync (.clk(codec_serial_clock), .rst(link_rst),
      .d(cfg_req_q), .q(cfg_req_s));
   crsf_sync3 u_cfg_ack_sync (.clk(clk), .rst(rst), .d(cfg_ack_q),
      .q(cfg_ack_s));
   crsf_sync3 u_word_req_sync (.clk(clk), .rst(rst), .d(word_req_q),
      .q(word_req_s));
   crsf_sync3 u_word_ack_sync (.clk(codec_serial_clock), .rst(link_rst),
      .d(word_ack_q), .q(word_ack_s));

   // hold register is stable while the request is outstanding
   always_ff @(posedge codec_serial_clock) begin
      if (link_rst) begin
         cfg_link_q <= 7'h00;
         cfg_ack_q <= 1'b0;
      end else if (cfg_req_s != cfg_ack_q) begin
         cfg_link_q <= cfg_hold_q;
         cfg_ack_q <= cfg_req_s;
      end
   end

   // ***************************************************************
   // link domain: slot receiver
   // ***************************************************************
   crsf_lstate_t lstate_q;
   logic [5:0] bit_q;
   logic [3:0] slot_q;
   logic [5:0] pos_bit;
   logic [3:0] pos_slot;
   logic [5:0] eff_len;
   logic [5:0] eff_width;
   logic [31:0] shift_q;
   logic [31:0] hold_q;
   logic [3:0] hold_slot_q;
   logic hold_lost_q;
   logic lost_q;
   logic live;
   logic slot_end;
   logic link_busy;

   assign live = lstate_q == CRSF_RUN || frame_sync;
   assign pos_bit = frame_sync ? 6'h00 : bit_q;
   assign pos_slot = frame_sync ? 4'h0 : slot_q;
   assign slot_end = live && pos_bit == eff_len - BIT_ONE;
   assign link_busy = word_req_q != word_ack_s;

   // geometry of the slot under way
   always_comb begin
      eff_len = DEF_LEN;
      eff_width = DEF_WIDTH;
      if (cfg_link_q[6]) begin
         eff_len = crsf_code_bits(cfg_link_q[LEN_SEL_MSB:LEN_SEL_LSB]);
         eff_width = crsf_code_bits(
            cfg_link_q[WIDTH_SEL_MSB:WIDTH_SEL_LSB]);
      end
      if (pos_slot == SEC_ADDR_SLOT || pos_slot == SEC_DATA_SLOT) begin
         eff_width = SEC_WIDTH;
      end
   end

   always_ff @(posedge codec_serial_clock) begin
      if (link_rst) begin
         lstate_q <= CRSF_HUNT;
      end else if (frame_sync) begin
         lstate_q <= CRSF_RUN;
      end
   end

   // every slot counts the same programmed length
   always_ff @(posedge codec_serial_clock) begin
      if (link_rst) begin
         bit_q <= 6'h00;
         slot_q <= 4'h0;
      end else if (slot_end) begin
         bit_q <= 6'h00;
         slot_q <= pos_slot + SLOT_ONE;
      end else if (live) begin
         bit_q <= pos_bit + BIT_ONE;
         slot_q <= pos_slot;
      end
   end

   // leading bits are kept, the tail of a long slot is dropped
   always_ff @(posedge codec_serial_clock) begin
      if (link_rst) begin
         shift_q <= ZERO32;
      end else if (live && pos_bit == 6'h00) begin
         shift_q <= {31'h00000000, serial_data};
      end else if (live && pos_bit < eff_width) begin
         shift_q <= {shift_q[30:0], serial_data};
      end
   end

   always_ff @(posedge codec_serial_clock) begin
      if (link_rst) begin
         hold_q <= ZERO32;
         hold_slot_q <= 4'h0;
         hold_lost_q <= 1'b0;
         lost_q <= 1'b0;
         word_req_q <= 1'b0;
      end else if (slot_end && !link_busy) begin
         if (pos_bit < eff_width) begin
            hold_q <= {shift_q[30:0], serial_data};
         end else begin
            hold_q <= shift_q;
         end
         hold_slot_q <= pos_slot;
         hold_lost_q <= lost_q;
         lost_q <= 1'b0;
         word_req_q <= ~word_req_q;
      end else if (slot_end) begin
         lost_q <= 1'b1;
      end
   end

   // ***************************************************************
   // received word into the register domain
   // ***************************************************************
   assign data_take = word_req_s != word_seen_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         word_seen_q <= 1'b0;
         word_ack_q <= 1'b0;
         rx_data_q <= ZERO32;
         rx_slot_q <= 4'h0;
         rx_lost_q <= 1'b0;
      end else if (data_take) begin
         word_seen_q <= word_req_s;
         word_ack_q <= word_req_s;
         rx_data_q <= hold_q;
         rx_slot_q <= hold_slot_q;
         rx_lost_q <= hold_lost_q;
      end
   end

   // a new word arriving with the clear keeps the flag set
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_new_q <= 1'b0;
      end else if (data_take) begin
         rx_new_q <= 1'b1;
      end else if (new_clr) begin
         rx_new_q <= 1'b0;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_mode_gate;
      @(posedge codec_serial_clock) disable iff (link_rst)
      !cfg_link_q[6] |-> eff_len == DEF_LEN;
   endproperty
   a_mode_gate: assert property (p_mode_gate)
      else $error("length not default outside mode 5");

   property p_width_code;
      @(posedge codec_serial_clock) disable iff (link_rst)
      cfg_link_q[6] && pos_slot != SEC_ADDR_SLOT
      && pos_slot != SEC_DATA_SLOT
      |-> eff_width == crsf_code_bits(cfg_link_q[5:3]);
   endproperty
   a_width_code: assert property (p_width_code)
      else $error("slot width does not follow its code");

   property p_sec_slot;
      @(posedge codec_serial_clock) disable iff (link_rst)
      pos_slot == SEC_ADDR_SLOT || pos_slot == SEC_DATA_SLOT
      |-> eff_width == SEC_WIDTH;
   endproperty
   a_sec_slot: assert property (p_sec_slot)
      else $error("secondary slot took programmed width");

   property p_len_code;
      @(posedge codec_serial_clock) disable iff (link_rst)
      cfg_link_q[6] |-> eff_len == crsf_code_bits(cfg_link_q[2:0]);
   endproperty
   a_len_code: assert property (p_len_code)
      else $error("slot length does not follow its code");

   property p_slot_wrap;
      @(posedge codec_serial_clock) disable iff (link_rst)
      slot_end ##1 !frame_sync
      |-> bit_q == 6'h00 && slot_q == $past(pos_slot) + SLOT_ONE;
   endproperty
   a_slot_wrap: assert property (p_slot_wrap)
      else $error("slot did not end after programmed length");

   property p_rsv_zero;
      @(posedge clk) disable iff (rst)
      addr_phase && !hwrite
      && haddr == crsf_byte_addr(IDX_SLOT_FORMAT)
      |=> hrdata[7:6] == 2'h0 && $stable(hreadyout);
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved bits read nonzero");

   property p_tail_drop;
      @(posedge codec_serial_clock) disable iff (link_rst)
      live && pos_bit >= eff_width && pos_bit != 6'h00
      |=> $past(shift_q) == shift_q || frame_sync || $past(slot_end);
   endproperty
   a_tail_drop: assert property (p_tail_drop)
      else $error("bit captured beyond data width");

   property p_word_flag;
      @(posedge clk) disable iff (rst)
      data_take |=> rx_new_q && rx_data_q == $past(hold_q);
   endproperty
   a_word_flag: assert property (p_word_flag)
      else $error("received word not posted");

endmodule // crsf_rx_slot_format

// >>> design/crsf_sync3.sv
`timescale 1ns/1ns
module crsf_sync3 (
   input wire logic clk, // destination clock
   input wire logic rst, // synchronous reset, high
   input wire logic d, // level from another domain
   output logic q // agreed level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once the second and third stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= 1'b0;
      end else if (s2_q == s3_q) begin
         q <= s3_q;
      end
   end
endmodule // crsf_sync3

// >>> tb/crsf_codec_model.sv
`timescale 1ns/1ns
module crsf_codec_model (
   output logic codec_serial_clock, // link clock, toggled only inside tick, stopped between calls
   output logic frame_sync, // marks bit 0 of slot 0
   output logic serial_data // slot bits, msb first
);
   // ***************************************************************
   // serial slot source
   // ***************************************************************
   initial begin
      codec_serial_clock = 1'b0;
      frame_sync = 1'b0;
      serial_data = 1'b0;
   end

   // slot number folded into every byte so a slot is recognisable
   function automatic logic [31:0] slot_word(input logic [3:0] s);
      slot_word = 32'hB4E1_96D2 ^ {8{s}};
   endfunction

   // lines change while the clock is low, sampled on its rise
   task automatic tick(input logic fs, input logic sd);
      frame_sync = fs;
      serial_data = sd;
      #3 codec_serial_clock = 1'b1;
      #3 codec_serial_clock = 1'b0;
   endtask

   // data line carries no slot here, so it alternates
   task automatic idle(input int n);
      repeat (n) tick(1'b0, ~serial_data);
   endtask

   task automatic send_frame(input int len, input int nslots);
      logic [31:0] w;
      for (int s = 0; s < nslots; s++) begin
         w = slot_word(s[3:0]);
         for (int b = 0; b < len; b++) begin
            tick(s == 0 && b == 0, w[31-b]);
         end
      end
      // partial tail lets the last slot word cross, never completes
      idle(len - 1);
      serial_data = ~serial_data;
   endtask
endmodule // crsf_codec_model

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import crsf_pkg::*;
   // ***************************************************************
   // signals and cases
   // ***************************************************************
   typedef struct {
      logic [2:0] mode;
      logic [7:0] fmt;
      logic [7:0] rd;
      int len;
      int nm;
      int ns;
   } crsf_row_t;
   logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic sclk, fsync, sdata;
   int failures, n_compared;
   crsf_row_t rows [10];

   assign hready = hreadyout;

   crsf_rx_slot_format i_crsf_rx_slot_format (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .codec_serial_clock(sclk), .frame_sync(fsync), .serial_data(sdata)
   );
   crsf_codec_model i_crsf_codec_model (
      .codec_serial_clock(sclk), .frame_sync(fsync), .serial_data(sdata)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ***************************************************************
   // bus and check tasks
   // ***************************************************************
   function automatic logic [31:0] ba(input logic [15:0] idx);
      ba = {14'h0000, idx, 2'h0};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
         chk("hreadyout", 32'h1, {31'h0, hreadyout});
         wrap_up();
      end
   endtask

   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] unused;
      xfer(1'b1, ba(idx), d, unused);
   endtask

   task automatic rd(input logic [15:0] idx, output logic [31:0] r);
      xfer(1'b0, ba(idx), 32'h0000_0000, r);
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      fork
         repeat (12) @(posedge clk);
         i_crsf_codec_model.idle(40);
      join
      rst <= 1'b0;
   endtask

   // collect posted slot words while a frame runs
   task automatic poll(input crsf_row_t r);
      logic [31:0] st, dv, dv2, ex;
      int n, got;
      got = 0;
      repeat (40) begin
         // data read on both sides of the status read: a word landing
         // in between would pair the data with the wrong slot number
         rd(IDX_RX_DATA, dv);
         rd(IDX_RX_STATUS, st);
         rd(IDX_RX_DATA, dv2);
         if (st[ST_NEW] === 1'b1 && dv === dv2) begin
            n = (st[ST_SLOT_MSB:ST_SLOT_LSB] inside {4'h1, 4'h2}) ?
                r.ns : r.nm;
            ex = i_crsf_codec_model.slot_word(st[ST_SLOT_MSB:ST_SLOT_LSB]);
            chk("rx_data", ex >> (32 - n), dv);
            wr(IDX_RX_STATUS, 32'h0000_0001);
            got++;
         end
      end
      chk("words_seen", 32'h1, {31'h0, got > 0});
   endtask

   // ***************************************************************
   // sequence
   // ***************************************************************
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      failures = 0;
      n_compared = 0;
      rows = '{'{3'h5, 8'hC5, 8'h05, 32, 8, 16},
               '{3'h5, 8'h0C, 8'h0C, 24, 16, 16},
               '{3'h5, 8'h13, 8'h13, 20, 18, 16},
               '{3'h5, 8'h1A, 8'h1A, 18, 18, 16},
               '{3'h5, 8'h21, 8'h21, 16, 16, 16},
               '{3'h5, 8'h68, 8'h28, 8, 8, 8},
               '{3'h5, 8'h2D, 8'h2D, 32, 32, 16},
               '{3'h5, 8'h37, 8'h37, 8, 8, 8},
               '{3'h0, 8'h2D, 8'h2D, 16, 16, 16},
               '{3'h4, 8'h05, 8'h05, 16, 16, 16}};
      foreach (rows[i]) begin
         do_reset();
         wr(IDX_PORT_CTRL, {29'h0, rows[i].mode});
         wr(IDX_SLOT_FORMAT, {24'h0, rows[i].fmt});
         rd(IDX_SLOT_FORMAT, rdv);
         chk("slot_format", {24'h0, rows[i].rd}, rdv);
         i_crsf_codec_model.idle(250);
         fork
            i_crsf_codec_model.send_frame(rows[i].len, 16);
            poll(rows[i]);
         join
         $display("case %0d done", i);
      end
      do_reset();
      rd(IDX_SLOT_FORMAT, rdv);
      chk("slot_format reset", 32'h0000_0000, rdv);
      rd(IDX_CONFIG_THREE, rdv);
      chk("config_three reset", {24'h0, CONFIG_THREE_RST}, rdv);
      wr(IDX_CONFIG_THREE, 32'hFFFF_FFA5);
      rd(IDX_CONFIG_THREE, rdv);
      chk("config_three", 32'h0000_00A5, rdv);
      wr(IDX_SLOT_FORMAT, 32'hFFFF_FFFF);
      rd(IDX_SLOT_FORMAT, rdv);
      chk("slot_format all ones", 32'h0000_003F, rdv);
      wr(16'h0123, 32'hFFFF_FFFF);
      rd(16'h0123, rdv);
      chk("unmapped", 32'h0000_0000, rdv);
      $display("register case done");
      wr(IDX_PORT_CTRL, {29'h0, MODE_I2S_5});
      i_crsf_codec_model.idle(300);
      rd(IDX_RX_STATUS, rdv);
      chk("status before frame", 32'h0000_0000, rdv);
      $display("no frame case done");
      wrap_up();
   end
endmodule // tb_top
